// *** shared/msff_pkg.sv ***
// Package for the master-slave flip-flop model
// Assumes a single synchronous clock domain (mclk) plus the asynchronous reset sys_rst
package msff_pkg;
    // ==========================================================
    // Reset values, clock period and encodings
    localparam logic MSFF_RST_STATE  = 1'b0;
    localparam logic MSFF_RST_MASTER = 1'b0;
    localparam logic MSFF_RST_CLK    = 1'b1;
    localparam int   MSFF_CLK_NS     = 5;

    typedef enum logic [1:0] {
        MSFF_OP_HOLD   = 2'b00,
        MSFF_OP_CLOCK  = 2'b01,
        MSFF_OP_SET    = 2'b11,
        MSFF_OP_CLEAR  = 2'b10
    } msff_op_t;
endpackage : msff_pkg

// *** logic/msff_latch.sv ***
// Transparent-low master latch, sampled model
// Assumes inputs synchronous to mclk
`timescale 1ns/1ps
module msff_latch (
    input  wire logic mclk,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    input  wire logic open_i,
    input  wire logic force_i,
    input  wire logic force_val,
    input  wire logic d_i,
    output logic      q_o
);
    // ==========================================================
    // Master stage: takes force_val while forced, else follows data while open, frozen otherwise
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            q_o <= msff_pkg::MSFF_RST_MASTER;
        end else if (clk_en) begin
            if (force_i) begin
                q_o <= force_val;
            end else if (open_i) begin
                q_o <= d_i;
            end
        end
    end
endmodule : msff_latch

// *** logic/msff_top.sv ***
// Master-slave D flip-flop with direct set and clear, sampled at mclk
// Assumes all inputs are synchronous to mclk; one mclk sample is one time step
`timescale 1ns/1ps
module msff_top (
    input  wire logic mclk,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    input  wire logic clock_pulse_in,
    input  wire logic clock_enable_n,
    input  wire logic data_in,
    input  wire logic direct_set,
    input  wire logic direct_clear,
    output logic      q_out,
    output logic      q_out_n,
    output logic      illegal_out
);
    // ==========================================================
    // Effective clock and edge detection
    logic            eff_clk;
    logic            eff_clk_q;
    logic            rise;
    logic            master_q;
    logic            state_q;
    logic            force_any;
    msff_pkg::msff_op_t op;

    assign eff_clk   = clock_pulse_in | clock_enable_n;
    assign rise      = eff_clk & ~eff_clk_q;
    assign force_any = direct_set | direct_clear;

    always_comb begin
        case ({direct_set, direct_clear})
            2'b10:   op = msff_pkg::MSFF_OP_SET;
            2'b01:   op = msff_pkg::MSFF_OP_CLEAR;
            2'b11:   op = msff_pkg::MSFF_OP_HOLD;
            default: op = rise ? msff_pkg::MSFF_OP_CLOCK : msff_pkg::MSFF_OP_HOLD;
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            eff_clk_q <= msff_pkg::MSFF_RST_CLK;
        end else if (clk_en) begin
            eff_clk_q <= eff_clk;
        end
    end

    // ==========================================================
    // Master latch; frozen while effective clock is high unless set or clear alone forces it
    msff_latch u_master (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .clk_en    (clk_en),
        .open_i    (~eff_clk),
        .force_i   (force_any & ~(direct_set & direct_clear)),
        .force_val (direct_set),
        .d_i       (data_in),
        .q_o       (master_q)
    );

    // ==========================================================
    // Slave state; the edge loads the master value as it stood before the edge
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= msff_pkg::MSFF_RST_STATE;
        end else if (clk_en) begin
            case (op)
                msff_pkg::MSFF_OP_SET:   state_q <= 1'b1;
                msff_pkg::MSFF_OP_CLEAR: state_q <= 1'b0;
                msff_pkg::MSFF_OP_CLOCK: state_q <= master_q;
                default:                 state_q <= state_q;
            endcase
        end
    end

    // ==========================================================
    // Outputs; both set and clear gives no defined level, so both read low and flag it
    always_comb begin
        if (direct_set & direct_clear) begin
            q_out       = 1'b0;
            q_out_n     = 1'b0;
            illegal_out = 1'b1;
        end else if (direct_set) begin
            q_out       = 1'b1;
            q_out_n     = 1'b0;
            illegal_out = 1'b0;
        end else if (direct_clear) begin
            q_out       = 1'b0;
            q_out_n     = 1'b1;
            illegal_out = 1'b0;
        end else begin
            q_out       = state_q;
            q_out_n     = ~state_q;
            illegal_out = 1'b0;
        end
    end

    // ==========================================================
    // Checks
    AST_SET_FORCES: assert property (@(posedge mclk) disable iff (sys_rst)
        (direct_set & ~direct_clear) |-> (q_out & ~q_out_n))
        else $error("Set did not force true output high");
    AST_CLR_FORCES: assert property (@(posedge mclk) disable iff (sys_rst)
        (direct_clear & ~direct_set) |-> (q_out_n & ~q_out))
        else $error("Clear did not force complement high");
    AST_BOTH_FLAG: assert property (@(posedge mclk) disable iff (sys_rst)
        illegal_out == (direct_set & direct_clear))
        else $error("Illegal flag wrong");
    AST_LOW_HOLD: assert property (@(posedge mclk) disable iff (sys_rst)
        (clk_en & ~eff_clk & ~force_any) |=> (state_q == $past(state_q)))
        else $error("Slave changed while clock low");
    AST_MASTER_FOLLOW: assert property (@(posedge mclk) disable iff (sys_rst)
        (clk_en & ~eff_clk & ~force_any) |=> (master_q == $past(data_in)))
        else $error("Master did not follow data");
    AST_EDGE_LOAD: assert property (@(posedge mclk) disable iff (sys_rst)
        (clk_en & rise & ~force_any) |=> (q_out == $past(master_q) || direct_set || direct_clear))
        else $error("Edge did not load master");
    AST_MASTER_FROZEN: assert property (@(posedge mclk) disable iff (sys_rst)
        (clk_en & eff_clk & ~force_any) |=> (master_q == $past(master_q)))
        else $error("Master moved while clock high");
    AST_ENABLE_FREEZE: assert property (@(posedge mclk) disable iff (sys_rst)
        (clk_en & clock_enable_n & eff_clk_q & ~force_any) |=> (state_q == $past(state_q)))
        else $error("State changed with enable high");
    AST_FORCE_KEPT: assert property (@(posedge mclk) disable iff (sys_rst)
        (clk_en & $fell(force_any) & ~rise) |=> (state_q == $past(state_q)))
        else $error("Forced state lost without edge");

    // ==========================================================
    // Further checks on forced, clocked and frozen behaviour
    AST_SET_STATE: assert property (@(posedge mclk) disable iff (sys_rst)
        (clk_en & direct_set & ~direct_clear) |=> state_q)
        else $error("Set did not reach stored state");

    AST_CLR_STATE: assert property (@(posedge mclk) disable iff (sys_rst)
        (clk_en & direct_clear & ~direct_set) |=> ~state_q)
        else $error("Clear did not reach stored state");

    AST_SET_MASTER: assert property (@(posedge mclk) disable iff (sys_rst)
        (clk_en & direct_set & ~direct_clear) |=> master_q)
        else $error("Set did not reach master");

    AST_CLR_MASTER: assert property (@(posedge mclk) disable iff (sys_rst)
        (clk_en & direct_clear & ~direct_set) |=> ~master_q)
        else $error("Clear did not reach master");

    AST_BOTH_LOW: assert property (@(posedge mclk) disable iff (sys_rst)
        (direct_set & direct_clear) |-> (~q_out & ~q_out_n))
        else $error("Outputs not parked low with set and clear");

    AST_BOTH_STATE: assert property (@(posedge mclk) disable iff (sys_rst)
        (clk_en & direct_set & direct_clear) |=> (state_q == $past(state_q)))
        else $error("State moved with set and clear");

    AST_BOTH_MASTER: assert property (@(posedge mclk) disable iff (sys_rst)
        (clk_en & direct_set & direct_clear) |=> (master_q == $past(master_q)))
        else $error("Master moved with set and clear");

    AST_OUT_COMPL: assert property (@(posedge mclk) disable iff (sys_rst)
        (~direct_set & ~direct_clear) |-> (q_out_n == ~q_out))
        else $error("Outputs not complementary");

    AST_OUT_STATE: assert property (@(posedge mclk) disable iff (sys_rst)
        (~direct_set & ~direct_clear) |-> (q_out == state_q))
        else $error("True output does not show state");

    AST_CP_HIGH_HOLD: assert property (@(posedge mclk) disable iff (sys_rst)
        (clk_en & ~force_any & clock_pulse_in & ~clock_enable_n & eff_clk_q) |=> (state_q == $past(state_q)))
        else $error("State changed with clock pulse held high");

    AST_EN_STATE: assert property (@(posedge mclk) disable iff (sys_rst)
        ~clk_en |=> (state_q == $past(state_q)))
        else $error("State moved while frozen");

    AST_EN_MASTER: assert property (@(posedge mclk) disable iff (sys_rst)
        ~clk_en |=> (master_q == $past(master_q)))
        else $error("Master moved while frozen");

    AST_EN_HISTORY: assert property (@(posedge mclk) disable iff (sys_rst)
        ~clk_en |=> (eff_clk_q == $past(eff_clk_q)))
        else $error("Clock history moved while frozen");

    AST_NO_RISE_HOLD: assert property (@(posedge mclk) disable iff (sys_rst)
        (clk_en & ~rise & ~force_any) |=> (state_q == $past(state_q)))
        else $error("State moved without an edge");

    AST_HISTORY_TRACK: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en |=> (eff_clk_q == $past(eff_clk)))
        else $error("Clock history not tracking");

    AST_EDGE_MASTER_HOLD: assert property (@(posedge mclk) disable iff (sys_rst)
        (clk_en & rise & ~force_any) |=> (master_q == $past(master_q)))
        else $error("Master moved on the edge");

    AST_CLOCKED_STATE: assert property (@(posedge mclk) disable iff (sys_rst)
        (clk_en & rise & ~force_any) |=> (state_q == $past(master_q)))
        else $error("Edge did not store master value");
endmodule : msff_top

// *** testbench/msff_src.sv ***
// Upstream driver model: clock pulse source and data feed
// Assumes mclk from the bench; changes just after rising edges
`timescale 1ns/1ps
module msff_src (
    input  wire logic mclk,
    input  wire logic run,
    input  wire logic toggle,
    input  wire logic d_req,
    input  wire logic q_n,
    output logic      cp,
    output logic      d
);
    // ==========================================
    // Clock pulse parks low when stopped
    initial cp = 1'b0;
    always @(posedge mclk) cp <= run ? ~cp : 1'b0;
    // Feedback gives divide-by-two
    assign d = toggle ? q_n : d_req;
endmodule : msff_src

// *** testbench/dff_async_set_clear_tb.sv ***
// Bench for the set/clear flip-flop
// Assumes msff_top and the upstream model msff_src
`timescale 1ns/1ps
module dff_async_set_clear_tb;
    logic mclk, sys_rst, ce_n, d_req, st, cl, run, tg, cp, d, q, qn, ill, en;
    int   fails, checks_done;
    msff_top dut_u (.mclk(mclk), .sys_rst(sys_rst), .clk_en(en), .clock_pulse_in(cp),
        .clock_enable_n(ce_n), .data_in(d), .direct_set(st), .direct_clear(cl),
        .q_out(q), .q_out_n(qn), .illegal_out(ill));
    msff_src src_u (.mclk(mclk), .run(run), .toggle(tg), .d_req(d_req), .q_n(qn), .cp(cp), .d(d));
    // ==========================================
    // Helpers
    task chk(input logic g, input logic e);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("Error %0t: output mismatch", $time);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask : cyc
    task results;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results
    // ==========================================
    // Scenarios
    task t_load;
        ce_n <= 1'b0; d_req <= 1'b1;
        cyc(1); ce_n <= 1'b1;
        cyc(2); chk(q, 1'b1); chk(qn, 1'b0);
        d_req <= 1'b0;
        cyc(3); chk(q, 1'b1);
        ce_n <= 1'b0;
        cyc(3); chk(q, 1'b1);
        ce_n <= 1'b1;
        cyc(2); chk(q, 1'b0);
        $display("load test done");
    endtask : t_load
    task t_force;
        st <= 1'b1; cyc(0); chk(q, 1'b1); chk(qn, 1'b0);
        st <= 1'b0; cyc(3); chk(q, 1'b1);
        cl <= 1'b1; cyc(0); chk(qn, 1'b1); chk(q, 1'b0);
        st <= 1'b1; cyc(0); chk(ill, 1'b1);
        st <= 1'b0; cl <= 1'b0; cyc(2); chk(q, 1'b0); chk(ill, 1'b0);
        $display("force test done");
    endtask : t_force
    task t_toggle;
        logic v;
        tg <= 1'b1; ce_n <= 1'b0; run <= 1'b1;
        cyc(4);
        repeat (3) begin
            v = q;
            cyc(2); chk(q, ~v);
        end
        cyc(1);
        ce_n <= 1'b1;
        cyc(1); run <= 1'b0;
        v = q;
        cyc(3); chk(q, v);
        $display("toggle test done");
    endtask : t_toggle
    task t_enable;
        logic v;
        tg <= 1'b0; v = q; d_req <= ~v; ce_n <= 1'b0; en <= 1'b0;
        cyc(2); ce_n <= 1'b1;
        cyc(2); chk(q, v);
        en <= 1'b1; ce_n <= 1'b0;
        cyc(2); ce_n <= 1'b1;
        cyc(2); chk(q, ~v);
        $display("enable test done");
    endtask : t_enable
    // ==========================================
    // Clock, watchdog, main sequence
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    initial begin
        #5000;
        fails++;
        results();
    end
    initial begin
        sys_rst = 1'b1; ce_n = 1'b1; d_req = 1'b0; st = 1'b0; cl = 1'b0; run = 1'b0; tg = 1'b0; en = 1'b1;
        fails = 0; checks_done = 0;
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        cyc(1);
        t_load();
        t_force();
        t_toggle();
        t_enable();
        results();
    end
endmodule : dff_async_set_clear_tb
